// *** hdl/trs_pkg.sv ***
// Shared constants and types for the result readout port
package trs_pkg;

  // System clock
  localparam int CLK_PERIOD_NS = 25;
  localparam real CLK_FREQ_MHZ = 40.0;

  // Longest wait from conversion done to ready flag, rounded down
  localparam real T_READY_MAX_US = 0.33;
  localparam int READY_MAX_RAW = $rtoi(T_READY_MAX_US * CLK_FREQ_MHZ);
  localparam int READY_MAX_CYC = (READY_MAX_RAW < 1) ? 1 : READY_MAX_RAW;

  // Frame geometry
  localparam int FRAME_BITS = 48;
  localparam int PAD_BITS = 7;
  localparam int WORD_BITS = FRAME_BITS - PAD_BITS;
  localparam int TAP_BITS = 16;
  localparam int ITER_BITS = 8;

  // Field positions inside the buffered word
  localparam int TAP1_LSB = 25;
  localparam int TAP2_LSB = 9;
  localparam int ITER_LSB = 1;
  localparam int DARK_POS = 0;

  // Bit counter
  localparam int CNT_BITS = 6;
  localparam logic [CNT_BITS-1:0] CNT_RST = 6'h00;
  localparam logic [CNT_BITS-1:0] CNT_TAKE = 6'h01;
  localparam logic [CNT_BITS-1:0] CNT_FULL = 6'h30;

  // Values after reset
  localparam logic CS_N_RST = 1'b1;
  localparam logic SCLK_RST = 1'b0;
  localparam logic [PAD_BITS-1:0] PAD_ZERO = 7'h00;

  typedef logic [WORD_BITS-1:0] trs_word_t;
  typedef logic [FRAME_BITS-1:0] trs_frame_t;

  typedef enum logic
  {
    LK_IDLE = 1'b0,
    LK_SHIFT = 1'b1
  } trs_link_e;

endpackage : trs_pkg

// *** hdl/trs_pair_buf.sv ***
// Two-entry result buffer with valid and ready on both sides
`timescale 1ns/10ps
module trs_pair_buf
  import trs_pkg::*;
#(
  parameter int W = WORD_BITS
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);

  logic [W-1:0] mem_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic push;
  logic pop;

  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign o_out_data = mem_q[rd_ptr_q];

  always_comb
  begin
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  // Flags registered so neither side sees a combinational path
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_q <= 2'h0;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      o_in_ready <= 1'b1;
      o_out_valid <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      o_in_ready <= (cnt_d != 2'h2);
      o_out_valid <= (cnt_d != 2'h0);
      if (push)
        wr_ptr_q <= ~wr_ptr_q;
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem_q[wr_ptr_q] <= i_in_data;
  end

  buf_depth_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cnt_q != 2'h3) && (o_in_ready == (cnt_q != 2'h2)))
    else $error("Buffer count or ready out of step");

endmodule : trs_pair_buf

// *** hdl/trs_readout.sv ***
// Serial result readout port of the distance sensor
//
// Behaviour
// - Raise ready flag when a frame is available
// - Flag rises within 0.33 us of conversion
// - One bit out per shift clock while selected
// - Data changes on rising, sampled on falling edge
// - Frame holds exactly 48 bits
// - Fields: tap1, tap2, iteration, dark, zero pad
// - Every field sent most significant bit first
// - Flag drops on second rising shift edge
// - Port is output only, takes no commands
// - Tap results are signed two's complement
// - Dark flag one without light trigger
// - Iteration count from last pixel reset
`timescale 1ns/10ps
module trs_readout
  import trs_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire logic I_CONV_DONE,
  input wire logic [TAP_BITS-1:0] I_FIRST_TAP_RESULT,
  input wire logic [TAP_BITS-1:0] I_SECOND_TAP_RESULT,
  input wire logic [ITER_BITS-1:0] I_ITER_COUNT,
  input wire logic I_DARK_FRAME,
  output logic O_CONV_READY,
  input wire logic I_CS_N,
  input wire logic I_SERIAL_SHIFT_CLOCK,
  output logic O_SERIAL_RESULT_OUT,
  output logic O_SERIAL_RESULT_OE,
  output logic O_RESULT_READY_FLAG
);

  localparam int READY_MAX = READY_MAX_CYC;

  // Pin synchronisers; stage three only feeds edge detection
  logic cs_n_s1_q;
  logic cs_n_s2_q;
  logic cs_n_s3_q;
  logic sclk_s1_q;
  logic sclk_s2_q;
  logic sclk_s3_q;

  logic cs_fall;
  logic cs_high;
  logic sclk_rise;

  trs_link_e link_q;
  logic active;
  logic [CNT_BITS-1:0] bit_cnt_q;
  logic [CNT_BITS-1:0] cnt_now;
  logic take;
  logic owns_q;

  trs_frame_t frame_q;
  trs_frame_t shift_q;
  trs_frame_t shift_src;
  logic frame_valid_q;

  trs_word_t conv_word;
  trs_word_t buf_data;
  logic buf_valid;
  logic buf_ready;

  // Word packing: signed taps, iteration count and dark flag pass as given
  assign conv_word = {I_FIRST_TAP_RESULT, I_SECOND_TAP_RESULT, I_ITER_COUNT, I_DARK_FRAME};

  // Two words of slack so a late reader does not drop a conversion
  trs_pair_buf #(
    .W(WORD_BITS)
  ) u_buf (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .i_in_valid(I_CONV_DONE),
    .o_in_ready(O_CONV_READY),
    .i_in_data(conv_word),
    .o_out_valid(buf_valid),
    .i_out_ready(buf_ready),
    .o_out_data(buf_data)
  );

  // Next frame only moves up once the held one has been claimed
  assign buf_ready = ~frame_valid_q;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      cs_n_s1_q <= CS_N_RST;
      cs_n_s2_q <= CS_N_RST;
      cs_n_s3_q <= CS_N_RST;
    end
    else
    begin
      cs_n_s1_q <= I_CS_N;
      cs_n_s2_q <= cs_n_s1_q;
      cs_n_s3_q <= cs_n_s2_q;
    end
  end

  // Shift clock is at most a quarter of the system clock, so sampling sees every edge
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      sclk_s1_q <= SCLK_RST;
      sclk_s2_q <= SCLK_RST;
      sclk_s3_q <= SCLK_RST;
    end
    else
    begin
      sclk_s1_q <= I_SERIAL_SHIFT_CLOCK;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
    end
  end

  assign cs_high = cs_n_s2_q;
  assign cs_fall = ~cs_n_s2_q & cs_n_s3_q;
  assign sclk_rise = sclk_s2_q & ~sclk_s3_q;

  // A select fall that lands with the first edge still counts that edge
  assign active = (link_q == LK_SHIFT) | cs_fall;
  assign cnt_now = cs_fall ? CNT_RST : bit_cnt_q;
  assign shift_src = cs_fall ? frame_q : shift_q;
  assign take = active & sclk_rise & (cnt_now == CNT_TAKE) & owns_q;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
      link_q <= LK_IDLE;
    else
    begin
      unique case (link_q)
        LK_IDLE:
        begin
          if (cs_fall)
            link_q <= LK_SHIFT;
        end
        LK_SHIFT:
        begin
          if (cs_high)
            link_q <= LK_IDLE;
        end
      endcase
    end
  end

  // Counter saturates at a full frame; edges while deselected are ignored
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
      bit_cnt_q <= CNT_RST;
    else if (active && sclk_rise && cnt_now != CNT_FULL)
      bit_cnt_q <= cnt_now + CNT_TAKE;
    else if (cs_fall)
      bit_cnt_q <= CNT_RST;
  end

  // Shift copy frees the held frame for the next conversion mid-transfer
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      shift_q <= '0;
      O_SERIAL_RESULT_OUT <= 1'b0;
    end
    else if (active && sclk_rise)
    begin
      O_SERIAL_RESULT_OUT <= shift_src[FRAME_BITS-1];
      shift_q <= {shift_src[FRAME_BITS-2:0], 1'b0};
    end
    else if (cs_fall)
      shift_q <= frame_q;
    else if (cs_high)
      O_SERIAL_RESULT_OUT <= 1'b0;
  end

  // Driver enabled only while selected; nothing is ever received
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
      O_SERIAL_RESULT_OE <= 1'b0;
    else
      O_SERIAL_RESULT_OE <= ~cs_high;
  end

  // Held frame with zero padding in the last seven bits
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
      frame_q <= '0;
    else if (buf_valid && buf_ready)
      frame_q <= {buf_data, PAD_ZERO};
  end

  // Flag follows frame ownership; a take and a load never share a cycle
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
      frame_valid_q <= 1'b0;
    else if (buf_valid && buf_ready)
      frame_valid_q <= 1'b1;
    else if (take)
      frame_valid_q <= 1'b0;
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
      O_RESULT_READY_FLAG <= 1'b0;
    else if (buf_valid && buf_ready)
      O_RESULT_READY_FLAG <= 1'b1;
    else if (take)
      O_RESULT_READY_FLAG <= 1'b0;
  end

  // Only a readout that copied a held frame may claim it; a frame landing mid-transfer keeps its flag
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
      owns_q <= 1'b0;
    else if (cs_fall)
      owns_q <= frame_valid_q;
  end

  default clocking cb @(posedge I_CLK_SYS);
  endclocking

  default disable iff (!I_RST_N);

  flag_raise_a: assert property (
    (buf_valid && !frame_valid_q) |=> O_RESULT_READY_FLAG)
    else $error("Ready flag not raised for waiting frame");

  ready_latency_a: assert property (
    (I_CONV_DONE && O_CONV_READY && !buf_valid && !frame_valid_q)
      |-> ##[1:READY_MAX] O_RESULT_READY_FLAG)
    else $error("Ready flag late after conversion");

  bit_step_a: assert property (
    (active && sclk_rise && cnt_now != CNT_FULL) |=> (bit_cnt_q == $past(cnt_now) + CNT_TAKE))
    else $error("Bit counter missed a shift edge");

  rise_launch_a: assert property (
    (!cs_high && !cs_fall && !(active && sclk_rise)) |=> $stable(O_SERIAL_RESULT_OUT))
    else $error("Serial data changed without a rising edge");

  frame_len_a: assert property (
    (bit_cnt_q == CNT_FULL && link_q == LK_SHIFT && !cs_high && sclk_rise)
      |=> (O_SERIAL_RESULT_OUT == 1'b0 && bit_cnt_q == CNT_FULL))
    else $error("Frame ran past its last bit");

  frame_layout_a: assert property (
    (buf_valid && buf_ready)
      |=> (frame_q[PAD_BITS-1:0] == PAD_ZERO
        && frame_q[FRAME_BITS-1 -: TAP_BITS] == $past(buf_data[TAP1_LSB +: TAP_BITS])
        && frame_q[PAD_BITS + TAP2_LSB +: TAP_BITS] == $past(buf_data[TAP2_LSB +: TAP_BITS])
        && frame_q[PAD_BITS + ITER_LSB +: ITER_BITS] == $past(buf_data[ITER_LSB +: ITER_BITS])))
    else $error("Frame fields misplaced");

  msb_first_a: assert property (
    (link_q == LK_SHIFT && owns_q && sclk_rise && bit_cnt_q == CNT_RST)
      |=> (O_SERIAL_RESULT_OUT == $past(frame_q[FRAME_BITS-1])))
    else $error("First bit is not the first tap MSB");

  dark_bit_a: assert property (
    (buf_valid && buf_ready) |=> (frame_q[PAD_BITS + DARK_POS] == $past(buf_data[DARK_POS])))
    else $error("Dark flag not carried into frame");

  flag_drop_a: assert property (
    (take && !buf_valid && !I_CONV_DONE) |=> !O_RESULT_READY_FLAG[*2])
    else $error("Ready flag not dropped on second edge");

  late_frame_keep_a: assert property (
    (!owns_q && frame_valid_q) |=> frame_valid_q)
    else $error("Frame arriving mid-transfer was claimed");

  output_only_a: assert property (
    cs_high |=> !O_SERIAL_RESULT_OE)
    else $error("Serial driver enabled while deselected");

  restart_a: assert property (
    (cs_fall && !sclk_rise) |=> (bit_cnt_q == CNT_RST && shift_q == $past(frame_q)))
    else $error("Frame position not restarted on select");

  idle_ignore_a: assert property (
    (link_q == LK_IDLE && !cs_fall) |=> $stable(bit_cnt_q))
    else $error("Shift edge counted while deselected");

  full_frame_c: cover property (
    (link_q == LK_SHIFT) && bit_cnt_q == CNT_FULL ##1 cs_high);

  flag_cycle_c: cover property (
    $rose(O_RESULT_READY_FLAG) ##[1:300] take);

  buffer_full_c: cover property (
    !O_CONV_READY && O_RESULT_READY_FLAG);

  reload_mid_frame_c: cover property (
    (link_q == LK_SHIFT) && buf_valid && buf_ready);

endmodule : trs_readout

// *** sim/trs_spi_master.sv ***
// Serial bus master model that reads result frames
`timescale 1ns/10ps
module trs_spi_master
(
  input wire logic i_data,
  input wire logic i_flag,
  output logic o_cs_n,
  output logic o_sclk
);
  logic [47:0] frame;
  logic flag_a;
  logic flag_b;

  initial
  begin
    o_cs_n = 1'h1;
    o_sclk = 1'h0;
  end

  // Shift edges with select high, must be ignored
  task stray(input int n);
    repeat (n)
    begin
      #100 o_sclk = 1'h1;
      #100 o_sclk = 1'h0;
    end
  endtask : stray

  // Half period kept long: data lags the pin edge by synchronizers
  task read(input int half, input int bits);
    frame = '0;
    o_cs_n = 1'h0;
    #(half);
    for (int i = 0; i < bits; i++)
    begin
      o_sclk = 1'h1;
      #(half);
      o_sclk = 1'h0;
      frame = {frame[46:0], i_data};
      if (i == 0) flag_a = i_flag;
      if (i == 3) flag_b = i_flag;
      #(half);
    end
    o_cs_n = 1'h1;
    #(half);
  endtask : read
endmodule : trs_spi_master

// *** sim/test_tof_result_spi_readout.sv ***
// Self-checking bench for the result readout port
`timescale 1ns/10ps
module test_tof_result_spi_readout
  import trs_pkg::*;
;
  logic clk;
  logic rst_n;
  logic done;
  logic [15:0] t1;
  logic [15:0] t2;
  logic [7:0] it;
  logic dk;
  logic conv_ready;
  logic cs_n;
  logic sclk;
  logic dout;
  logic oe;
  logic flag;
  int miscompares;
  int checks_done;
  int n;
  bit took;
  bit refused;
  trs_frame_t q[$];
  trs_frame_t e;

  always #12.5 clk = ~clk;

  trs_readout dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CONV_DONE(done),
    .I_FIRST_TAP_RESULT(t1), .I_SECOND_TAP_RESULT(t2), .I_ITER_COUNT(it),
    .I_DARK_FRAME(dk), .O_CONV_READY(conv_ready), .I_CS_N(cs_n),
    .I_SERIAL_SHIFT_CLOCK(sclk), .O_SERIAL_RESULT_OUT(dout),
    .O_SERIAL_RESULT_OE(oe), .O_RESULT_READY_FLAG(flag));

  trs_spi_master m (.i_data(dout), .i_flag(flag), .o_cs_n(cs_n), .o_sclk(sclk));

  function automatic trs_frame_t exp_frame(input logic [15:0] a, input logic [15:0] b,
    input logic [7:0] c, input logic d);
    return {a, b, c, d, PAD_ZERO};
  endfunction : exp_frame

  task chk_val(input string name, input logic [47:0] exp, input logic [47:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_val

  task end_of_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  // Word offered for one cycle; refused words are simply dropped
  task offer(input logic [15:0] a, input logic [15:0] b, input logic [7:0] c, input logic d);
    @(negedge clk);
    {t1, t2, it, dk} = {a, b, c, d};
    done = 1'h1;
    took = conv_ready;
    @(negedge clk);
    done = 1'h0;
    if (took)
      q.push_back(exp_frame(a, b, c, d));
    else
      refused = 1'b1;
  endtask : offer

  task wait_flag;
    n = 0;
    while (flag !== 1'h1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 40)
    begin
      miscompares++;
      end_of_test();
    end
  endtask : wait_flag

  task read_one(input int half);
    wait_flag();
    m.read(half, 48);
    e = q.pop_front();
    chk_val("frame", e, m.frame);
  endtask : read_one

  initial
  begin
    clk = 1'h0;
    rst_n = 1'h0;
    done = 1'h0;
    {t1, t2, it, dk} = '0;
    miscompares = 0;
    checks_done = 0;
    refused = 1'b0;
    n = $urandom(30);
    repeat (8) @(negedge clk);
    rst_n = 1'h1;
    m.stray(3);
    offer(16'h8000, 16'h7FFF, 8'hFF, 1'h1);
    wait_flag();
    chk_val("ready delay", 1'h1, n + 1 <= READY_MAX_CYC);
    fork
      m.read(200, 48);
      begin
        #2000;
        chk_val("drive enable", 1'h1, oe);
      end
    join
    e = q.pop_front();
    chk_val("frame", e, m.frame);
    chk_val("flag first edge", 1'h1, m.flag_a);
    chk_val("flag later edge", 1'h0, m.flag_b);
    repeat (5) @(negedge clk);
    chk_val("idle enable", 1'h0, oe);
    chk_val("idle data", 1'h0, dout);
    offer(16'hFFFF, 16'h0000, 8'h00, 1'h0);
    wait_flag();
    m.read(200, 10);
    e = q.pop_front();
    chk_val("partial frame", e[47:38], m.frame[9:0]);
    m.read(200, 48);
    chk_val("restart frame", e, m.frame);
    // Offer six words so some are refused, then drain with prompt and slow master
    for (int i = 0; i < 6; i++)
      offer($urandom, $urandom, $urandom, $urandom);
    chk_val("refusal seen", 1'h1, refused);
    while (q.size() > 0)
      read_one(($urandom % 2) ? 400 : 200);
    for (int i = 0; i < 5; i++)
    begin
      offer($urandom, $urandom, $urandom, $urandom);
      read_one(200);
    end
    // Two extra edges past the frame must shift out zeros
    offer($urandom, $urandom, $urandom, $urandom);
    wait_flag();
    m.read(200, 50);
    e = q.pop_front();
    chk_val("overrun frame", {e[45:0], 2'h0}, m.frame);
    chk_val("ready after drain", 1'h1, conv_ready);
    end_of_test();
  end
endmodule : test_tof_result_spi_readout
